/* address_mapper.sv */
// Logical to physical address mapper: three boundary/base registers on
// the internal I/O write port, comparators and a page adder.
// Assumes CPU and DMA signals are synchronous to clock; I/O writes are
// single-cycle strobes, one bus cycle per clock.
`timescale 1ns/1ns
`include "address_mapper_map.svh"
module address_mapper #(
  parameter int LOGICAL_WIDTH  = 16,
  parameter int PHYSICAL_WIDTH = 20
) (
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // Internal I/O register port
  input  wire logic                      io_write,
  input  wire logic                      io_read,
  input  wire logic [7:0]                io_address,
  input  wire logic [7:0]                io_write_data,
  output logic      [7:0]                io_read_data,
  output logic                           io_read_hit,
  // CPU address side
  input  wire logic [LOGICAL_WIDTH-1:0]  logical_address,
  input  wire logic                      io_cycle,
  // DMA ownership of the bus
  input  wire logic                      dma_owns_bus,
  input  wire logic [PHYSICAL_WIDTH-1:0] dma_address,
  // Package options
  input  wire logic                      top_bit_absent,
  input  wire logic                      timer_output_pin_enable,
  // Physical side
  output logic [PHYSICAL_WIDTH-1:0]      physical_address,
  output address_mapper_pkg::area_type   current_area
);

  localparam int PAGE_LSB = `MAP_PAGE_LSB;
  localparam int PAGE_W   = PHYSICAL_WIDTH - PAGE_LSB;

  logic [7:0] upper_common_base;
  logic [7:0] bank_area_base;
  logic [7:0] area_boundary_register;
  logic [3:0] upper_common_start;
  logic [3:0] bank_start;
  logic [3:0] logical_page;
  logic [7:0] selected_base;
  logic [PAGE_W-1:0] physical_page;
  logic [PHYSICAL_WIDTH-1:0] next_physical_address;
  address_mapper_pkg::area_type   area;
  address_mapper_pkg::source_type source;

  // Shared address decode for reads and writes
  function automatic logic hit(input logic [7:0] address,
                               input logic [7:0] offset);
    hit = (address == offset);
  endfunction : hit

  // Upper common base; new value serves the very next cycle
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      upper_common_base <= `MAP_UPPER_COMMON_BASE_RESET;
    end else if (io_write && hit(io_address, `MAP_UPPER_COMMON_BASE_ADDR)) begin
      upper_common_base <= io_write_data;
    end
  end

  // Bank area base
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bank_area_base <= `MAP_BANK_AREA_BASE_RESET;
    end else if (io_write && hit(io_address, `MAP_BANK_AREA_BASE_ADDR)) begin
      bank_area_base <= io_write_data;
    end
  end

  // Area boundary; ordering of the fields is left to software
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      area_boundary_register <= `MAP_AREA_BOUNDARY_RESET;
    end else if (io_write && hit(io_address, `MAP_AREA_BOUNDARY_ADDR)) begin
      area_boundary_register <= io_write_data;
    end
  end

  // Read-back registered so the data output comes from flip-flops
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      io_read_data <= 8'h00;
    end else if (io_read) begin
      if (hit(io_address, `MAP_UPPER_COMMON_BASE_ADDR)) begin
        io_read_data <= upper_common_base;
      end else if (hit(io_address, `MAP_BANK_AREA_BASE_ADDR)) begin
        io_read_data <= bank_area_base;
      end else if (hit(io_address, `MAP_AREA_BOUNDARY_ADDR)) begin
        io_read_data <= area_boundary_register;
      end else begin
        io_read_data <= 8'h00;
      end
    end
  end

  // Combinational flag: the read address belongs to this block
  assign io_read_hit = io_read &&
    (hit(io_address, `MAP_UPPER_COMMON_BASE_ADDR) ||
     hit(io_address, `MAP_BANK_AREA_BASE_ADDR) ||
     hit(io_address, `MAP_AREA_BOUNDARY_ADDR));

  // Boundary fields and the logical page number
  assign upper_common_start =
    area_boundary_register[`MAP_UPPER_START_MSB:`MAP_UPPER_START_LSB];
  assign bank_start =
    area_boundary_register[`MAP_BANK_START_MSB:`MAP_BANK_START_LSB];
  assign logical_page = logical_address[LOGICAL_WIDTH-1 -: 4];

  area_classifier u_area_classifier (
    .logical_page       (logical_page),
    .upper_common_start (upper_common_start),
    .bank_start         (bank_start),
    .area               (area)
  );

  // Base selection by area
  always_comb begin
    case (area)
      address_mapper_pkg::area_upper_common:
        selected_base = upper_common_base;
      address_mapper_pkg::area_bank:
        selected_base = bank_area_base;
      address_mapper_pkg::area_lower_common:
        selected_base = 8'h00;
      default:
        selected_base = 8'h00;
    endcase
  end

  // Page adder; result cut to the page width so carry out is lost
  assign physical_page = PAGE_W'(selected_base + {4'h0, logical_page});

  // DMA wins over everything, then I/O, then memory translation
  always_comb begin
    if (dma_owns_bus) begin
      source = address_mapper_pkg::source_dma;
    end else if (io_cycle) begin
      source = address_mapper_pkg::source_io;
    end else begin
      source = address_mapper_pkg::source_memory;
    end
  end

  // Address assembly, then the narrow-package mask
  always_comb begin
    case (source)
      address_mapper_pkg::source_dma:
        next_physical_address = dma_address;
      address_mapper_pkg::source_io:
        next_physical_address = {{(PHYSICAL_WIDTH-LOGICAL_WIDTH){1'b0}},
                                 logical_address};
      default:
        next_physical_address = {physical_page,
                                 logical_address[PAGE_LSB-1:0]};
    endcase
    // Missing top pin: only 512K reachable; bit 18 lent to the timer: only 256K reachable
    if (top_bit_absent || timer_output_pin_enable) begin
      next_physical_address[PHYSICAL_WIDTH-1] = 1'b0;
    end
    if (timer_output_pin_enable) begin
      next_physical_address[PHYSICAL_WIDTH-2] = 1'b0;
    end
  end

  // Address out of flip-flops: registers update at the edge ending the
  // write cycle, so the following cycle is translated with new values
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      physical_address <= '0;
      current_area     <= address_mapper_pkg::area_lower_common;
    end else begin
      physical_address <= next_physical_address;
      current_area     <= area;
    end
  end

endmodule : address_mapper

/* address_mapper_map.svh */
// Register offsets, field positions, reset values and widths of the
// logical to physical address mapper.
// Assumes inclusion by bare name; definitions only.
`ifndef ADDRESS_MAPPER_MAP_SVH
`define ADDRESS_MAPPER_MAP_SVH

// I/O offsets of the mapping registers
`define MAP_UPPER_COMMON_BASE_ADDR 8'h38
`define MAP_BANK_AREA_BASE_ADDR    8'h39
`define MAP_AREA_BOUNDARY_ADDR     8'h3a

// Reset values
`define MAP_UPPER_COMMON_BASE_RESET 8'h00
`define MAP_BANK_AREA_BASE_RESET    8'h00
`define MAP_AREA_BOUNDARY_RESET     8'hf0

// Field positions inside the boundary register
`define MAP_UPPER_START_MSB 7
`define MAP_UPPER_START_LSB 4
`define MAP_BANK_START_MSB  3
`define MAP_BANK_START_LSB  0

// Page geometry: 4KB pages, page number in top logical bits
`define MAP_PAGE_LSB 12

`endif

/* address_mapper_pkg.sv */
// Types shared by the address mapper design files.
// Assumes nothing beyond a SystemVerilog compiler.
package address_mapper_pkg;

  // Logical area selected by the comparators
  typedef enum logic [2:0] {
    area_lower_common = 3'b001,
    area_bank         = 3'b010,
    area_upper_common = 3'b100
  } area_type;

  // Source of the physical address
  typedef enum logic [2:0] {
    source_memory = 3'b001,
    source_io     = 3'b010,
    source_dma    = 3'b100
  } source_type;

endpackage : address_mapper_pkg

/* area_classifier.sv */
// Comparator stage: sorts a logical page into one of three areas.
// Assumes boundary fields come from the same clock domain, no sync needed.
`timescale 1ns/1ns
module area_classifier (
  input  wire logic [3:0]                  logical_page,
  input  wire logic [3:0]                  upper_common_start,
  input  wire logic [3:0]                  bank_start,
  output address_mapper_pkg::area_type     area
);

  // Upper boundary checked first so an equal pair yields no bank area
  always_comb begin
    if (logical_page >= upper_common_start) begin
      area = address_mapper_pkg::area_upper_common;
    end else if (logical_page >= bank_start) begin
      area = address_mapper_pkg::area_bank;
    end else begin
      area = address_mapper_pkg::area_lower_common;
    end
  end

endmodule : area_classifier

/* cpu_model.sv */
// CPU core stand-in: register strobes and logical addresses.
// Assumes the bench calls drive just after a falling clock edge.
`timescale 1ns/1ns
module cpu_model (
  output logic        io_write,
  output logic        io_read,
  output logic        io_cycle,
  output logic [7:0]  io_address,
  output logic [7:0]  io_write_data,
  output logic [15:0] logical_address
);
  initial drive(3'b000, 8'h00, 8'h00, 16'h0000);
  // One bus cycle; write data flips when idle so no stale byte is seen.
  // Mapping code is taken to run from an always-mapped area
  task automatic drive(input logic [2:0] k, input logic [7:0] a, d,
                       input logic [15:0] la);
    {io_write, io_read, io_cycle} = k;
    io_address = a;
    io_write_data = k[2] ? d : ~d;
    logical_address = la;
  endtask : drive
endmodule : cpu_model

/* mapper_sva.sv */
// Checker for the address mapper, bound onto its ports.
// Assumes one clock domain and the async active-low reset.
`timescale 1ns/1ns
module mapper_sva (
  input wire logic clock, reset_n, dma_owns_bus, io_cycle,
  input wire logic top_bit_absent, timer_output_pin_enable,
  input wire logic [15:0] logical_address,
  input wire logic [19:0] dma_address, physical_address,
  input wire address_mapper_pkg::area_type current_area
);
  // Pin options off, so pass-through values stay whole
  wire plain = !top_bit_absent && !timer_output_pin_enable;
  wire mem = plain && !dma_owns_bus && !io_cycle;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  dma_pass_a: assert property (
    dma_owns_bus && plain |=> physical_address == $past(dma_address))
    else $error("dma address not passed");
  io_pass_a: assert property (
    !dma_owns_bus && io_cycle && plain
    |=> physical_address == {4'h0, $past(logical_address)})
    else $error("io address not passed");
  low_bits_a: assert property (!dma_owns_bus |=>
    physical_address[11:0] == $past(logical_address[11:0]))
    else $error("offset bits changed");
  top_bit_a: assert property (top_bit_absent |=>
    !physical_address[19]) else $error("bit 19 set without pin");
  timer_pin_a: assert property (timer_output_pin_enable |=>
    physical_address[19:18] == 2'h0) else $error("bits 19:18 set");
  lower_zero_a: assert property (
    mem ##1 current_area == address_mapper_pkg::area_lower_common
    |-> physical_address[19:12] == $past(logical_address[15:12]))
    else $error("lower area not zero based");
  reset_map_a: assert property ($rose(reset_n) |->
    physical_address == 20'h00000) else $error("reset address not zero");
  area_hot_a: assert property ($onehot(current_area))
    else $error("area not one-hot");
  cover property (dma_owns_bus);
  cover property (mem && io_cycle == 1'b0);
  cover property (current_area == address_mapper_pkg::area_bank);
endmodule : mapper_sva
bind address_mapper mapper_sva chk_u (.*);

/* testbench.sv */
// Bench: random and corner traffic through the address mapper.
// Assumes cpu_model drives the CPU side; the bench owns DMA and pins.
`timescale 1ns/1ns
module testbench;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        dma_owns_bus = 1'b0;
  logic        top_bit_absent = 1'b0;
  logic        timer_output_pin_enable = 1'b0;
  logic [19:0] dma_address = 20'h00000;
  logic [19:0] physical_address, m;
  logic        io_write, io_read, io_cycle, io_read_hit;
  logic [7:0]  io_address, io_write_data, io_read_data, cb, bb, bnd;
  logic [15:0] logical_address, la;
  logic [31:0] r1, r2;
  int          errors = 0;
  int          n_tests = 0;
  int          cyc = 0;
  address_mapper_pkg::area_type current_area;
  cpu_model      cpu_u (.*);
  address_mapper dut_u (.*);
  always #25 clock = ~clock;
  // Hang guard: the run needs well under 2000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 2000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [19:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wrap_up();
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up
  // Register write; shadows follow so the next cycle expects the new map
  task automatic wr(input logic [7:0] a, d);
    @(negedge clock) cpu_u.drive(3'b100, a, d, logical_address);
    if (a == 8'h38) cb = d;
    if (a == 8'h39) bb = d;
    if (a == 8'h3a) bnd = d;
  endtask : wr
  // Register read: hit in the strobe cycle, data one cycle later
  task automatic rd(input logic [7:0] a, exp, input logic hit);
    @(negedge clock) cpu_u.drive(3'b010, a, 8'h00, logical_address);
    #1 check(io_read_hit, hit);
    @(negedge clock) cpu_u.drive(3'b000, a, 8'h00, logical_address);
    check(io_read_data, exp);
  endtask : rd
  // One access, compared on the cycle after it is sampled
  task automatic acc(input logic io, input logic [15:0] a,
                     input logic [19:0] exp);
    @(negedge clock) cpu_u.drive({2'b00, io}, 8'h00, 8'h00, a);
    @(negedge clock) check(physical_address, exp);
  endtask : acc
  // Expected address from shadow registers; carry past bit 19 is lost
  function automatic logic [19:0] xlat(input logic [15:0] a);
    logic [7:0] b;
    b = a[15:12] >= bnd[7:4] ? cb : a[15:12] >= bnd[3:0] ? bb : 8'h00;
    return {b + {4'h0, a[15:12]}, a[11:0]} & m;
  endfunction : xlat
  // Expected one-hot area: upper start checked before bank start
  function automatic logic [2:0] xarea(input logic [15:0] a);
    return a[15:12] >= bnd[7:4] ? 3'b100 :
           a[15:12] >= bnd[3:0] ? 3'b010 : 3'b001;
  endfunction : xarea
  initial begin
    void'($urandom(32'he496ed37));
    {cb, bb, bnd, m} = {16'h0000, 8'hf0, 20'hfffff};
    repeat (10) @(negedge clock);
    reset_n = 1'b1;
    rd(8'h38, 8'h00, 1'b1);
    rd(8'h39, 8'h00, 1'b1);
    rd(8'h3a, 8'hf0, 1'b1);
    rd(8'h3b, 8'h00, 1'b0);
    acc(1'b0, 16'hfedc, 20'h0fedc);
    wr(8'h38, 8'hff);
    acc(1'b0, 16'hf123, 20'h0e123);
    repeat (40) begin
      r1 = $urandom;
      r2 = $urandom;
      // Upper start kept at or above bank start
      wr(8'h3a, r1[7:4] >= r1[3:0] ? r1[7:0] : {r1[3:0], r1[7:4]});
      wr(8'h38, r2[7:0]);
      wr(8'h39, r2[15:8]);
      {timer_output_pin_enable, top_bit_absent} = r2[17:16];
      m = {~|r2[17:16], ~r2[17], 18'h3ffff};
      // Random page, then both start pages and the page below bank start
      for (int i = 0; i < 4; i++) begin
        la = {i == 0 ? r1[31:28] : i == 1 ? bnd[3:0] :
              i == 2 ? bnd[3:0] - 4'h1 : bnd[7:4], r1[27:16]};
        acc(1'b0, la, xlat(la));
        check(current_area, xarea(la));
      end
      acc(1'b1, la, {4'h0, la} & m);
      rd(8'h39, bb, 1'b1);
      dma_owns_bus = 1'b1;
      dma_address = {r1[3:0], r2[31:16]};
      acc(1'b0, la, dma_address & m);
      dma_owns_bus = 1'b0;
    end
    wrap_up();
  end
endmodule : testbench
